// File: src/fesc_map.vh
// register offsets, fields, command codes and timing values in ns for the flash erase suspend controller
`ifndef FESC_MAP_VH
`define FESC_MAP_VH
// ------------------------------------------------------------
// apb register offsets
// ------------------------------------------------------------
`define FESC_REG_CTRL      12'h000
`define FESC_REG_ADDR      12'h004
`define FESC_REG_DATA      12'h008
`define FESC_REG_STATUS    12'h00c
`define FESC_REG_RDATA     12'h010
`define FESC_REG_SUSPCODE  12'h014
// ------------------------------------------------------------
// control register commands (written to CTRL[2:0])
// ------------------------------------------------------------
`define FESC_OP_NONE       3'h0
`define FESC_OP_WRITE      3'h1
`define FESC_OP_READ       3'h2
`define FESC_OP_SUSPEND    3'h3
`define FESC_OP_RESUME     3'h4
`define FESC_OP_WAITSUSP   3'h5
`define FESC_OP_POLL       3'h6
// ------------------------------------------------------------
// status bit positions in the flash data byte
// ------------------------------------------------------------
`define FESC_DQ_POLL       7
`define FESC_DQ_TOG1       6
`define FESC_DQ_FAIL       5
`define FESC_DQ_WIN        3
`define FESC_DQ_TOG2       2
// ------------------------------------------------------------
// command bytes and reset values
// ------------------------------------------------------------
`define FESC_CMD_RESUME    8'h30
`define FESC_CMD_SUSP_RST  8'hb0
// ------------------------------------------------------------
// timing: bus phase in ns and suspend wait in ns
// ------------------------------------------------------------
`define FESC_CLK_NS        20
`define FESC_PHASE_NS      100
`define FESC_SUSP_MAX_NS   15000
`endif

// File: src/fesc_ctrl.v
// host-side flash erase suspend/resume and status controller with an apb register slave
// Function
// RQ1: suspend honoured only during erase or window
// RQ2: suspend in window ends window, suspends
// RQ3: suspended device takes reset, program, resume
// RQ4: suspend and resume decoded from data only
// RQ5: suspension completes within 0.2 to 15 us
// RQ6: host checks toggle bit or ready line
// RQ7: repeated suspend or resume is ignored
// RQ8: suspended device defaults to suspend-read mode
// RQ9: byte 30h resumes; unlimited suspend cycles
// RQ10: protected sector status briefly active only
// RQ11: busy line low while algorithm runs
// RQ12: busy line high when suspended or failed
// RQ13: busy line open drain, wired-and
// RQ14: poll bit inverse while program, zero erase
// RQ15: toggle bit one inverts each read
// RQ16: toggle valid after last command write
// RQ17: fail bit set on timeout or bad program
// RQ18: host resets device after failure
// RQ19: window bit one once erase under way
// RQ20: host reads window bit around sector commands
// RQ21: toggle bit two only in erasing sectors
// RQ22: write strobe restarts erase window
// RQ23: erase starts when window times out
// RQ24: suspend code is a configurable constant
`timescale 1ns/1ns
`include "fesc_map.vh"
module fesc_ctrl #(
   parameter ADDR_W      = 20,
   parameter SUSP_CYCLES = `FESC_SUSP_MAX_NS / `FESC_CLK_NS
) (
   input  wire              CLK_I,
   input  wire              RESETN_I,
   input  wire              PSEL_I,
   input  wire              PENABLE_I,
   input  wire              PWRITE_I,
   input  wire [11:0]       PADDR_I,
   input  wire [31:0]       PWDATA_I,
   output wire [31:0]       PRDATA_O,
   output wire              PREADY_O,
   output wire              PSLVERR_O,
   output reg  [ADDR_W-1:0] FL_ADDR_O,
   output reg               FL_CE_N_O,
   output reg               FL_OE_N_O,
   output reg               FL_WE_N_O,
   input  wire [7:0]        FL_DQ_I,
   output reg  [7:0]        FL_DQ_O,
   output reg               FL_DQ_OE_O,
   input  wire              FL_READY_BUSY_N_I,
   output reg               FL_RESET_N_O
);
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
localparam PHASE_CYC = (`FESC_PHASE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS;
// ------------------------------------------------------------
// states, one-hot
// ------------------------------------------------------------
localparam [5:0] ST_IDLE  = 6'h01;
localparam [5:0] ST_SETUP = 6'h02;
localparam [5:0] ST_STROB = 6'h04;
localparam [5:0] ST_HOLD  = 6'h08;
localparam [5:0] ST_WAIT  = 6'h10;
localparam [5:0] ST_DONE  = 6'h20;
reg  [5:0]        state_q;
reg  [2:0]        op_q;
reg  [ADDR_W-1:0] addr_q;
reg  [7:0]        wdata_q;
reg  [7:0]        rdata_q;
reg  [7:0]        prev_q;
reg  [7:0]        susp_code_q;
reg               busy_q;
reg               timeout_q;
reg               suspended_q;
reg               erasing_q;
reg               in_erase_q;
reg               fail_q;
reg               tog1_q;
reg               tog2_q;
reg               have_prev_q;
reg  [15:0]       phase_q;
reg  [15:0]       wait_q;
reg               rb_m_q;
reg               rb_q;
reg  [31:0]       prdata_q;
// ------------------------------------------------------------
// apb slave: zero wait, unmapped reads return zero with error
// ------------------------------------------------------------
wire acc  = PSEL_I & PENABLE_I;
wire wr   = acc & PWRITE_I;
wire hit_ctrl = (PADDR_I == `FESC_REG_CTRL);
function mapped;
   input [11:0] a;
   begin
      mapped = (a == `FESC_REG_CTRL) || (a == `FESC_REG_ADDR) || (a == `FESC_REG_DATA) ||
               (a == `FESC_REG_STATUS) || (a == `FESC_REG_RDATA) || (a == `FESC_REG_SUSPCODE);
   end
endfunction
assign PREADY_O  = 1'b1;
assign PSLVERR_O = acc & ~mapped(PADDR_I);
assign PRDATA_O  = prdata_q;
wire [31:0] status_w = {18'h0, erasing_q, suspended_q, in_erase_q, fail_q, tog2_q, tog1_q, rb_q, timeout_q, busy_q,
                        5'h0};
always @* begin
   if (PADDR_I == `FESC_REG_CTRL) prdata_q = {29'h0, op_q};
   else if (PADDR_I == `FESC_REG_ADDR) prdata_q = {{(32-ADDR_W){1'b0}}, addr_q};
   else if (PADDR_I == `FESC_REG_DATA) prdata_q = {24'h0, wdata_q};
   else if (PADDR_I == `FESC_REG_STATUS) prdata_q = status_w;
   else if (PADDR_I == `FESC_REG_RDATA) prdata_q = {24'h0, rdata_q};
   else if (PADDR_I == `FESC_REG_SUSPCODE) prdata_q = {24'h0, susp_code_q};
   else prdata_q = 32'h0;
end
wire start = wr & hit_ctrl & ~busy_q & (PWDATA_I[2:0] != `FESC_OP_NONE);
wire [7:0] new_dq = FL_DQ_I;
// ------------------------------------------------------------
// ready/busy synchroniser; line is open drain, pulled up outside
// ------------------------------------------------------------
always @(posedge CLK_I) begin
   if (!RESETN_I) begin
      rb_m_q <= 1'b1;
      rb_q   <= 1'b1;
   end else begin
      rb_m_q <= FL_READY_BUSY_N_I; // see RQ13
      rb_q   <= rb_m_q;
   end
end
// ------------------------------------------------------------
// flash bus sequencer
// ------------------------------------------------------------
always @(posedge CLK_I) begin
   if (!RESETN_I) begin
      state_q <= ST_IDLE; op_q <= `FESC_OP_NONE; busy_q <= 1'b0;
      addr_q <= {ADDR_W{1'b0}}; wdata_q <= 8'h0; rdata_q <= 8'h0; prev_q <= 8'h0;
      susp_code_q <= `FESC_CMD_SUSP_RST; timeout_q <= 1'b0; suspended_q <= 1'b0;
      erasing_q <= 1'b0; in_erase_q <= 1'b0; fail_q <= 1'b0; tog1_q <= 1'b0; tog2_q <= 1'b0;
      have_prev_q <= 1'b0; phase_q <= 16'h0; wait_q <= 16'h0;
      FL_ADDR_O <= {ADDR_W{1'b0}}; FL_CE_N_O <= 1'b1; FL_OE_N_O <= 1'b1; FL_WE_N_O <= 1'b1;
      FL_DQ_O <= 8'h0; FL_DQ_OE_O <= 1'b0; FL_RESET_N_O <= 1'b1;
   end else begin
      if (wr && PADDR_I == `FESC_REG_ADDR && !busy_q) addr_q <= PWDATA_I[ADDR_W-1:0];
      if (wr && PADDR_I == `FESC_REG_DATA && !busy_q) wdata_q <= PWDATA_I[7:0];
      if (wr && PADDR_I == `FESC_REG_SUSPCODE && PWDATA_I[7:0] != `FESC_CMD_RESUME)
         susp_code_q <= PWDATA_I[7:0]; // see RQ24
      if (wr && hit_ctrl && PWDATA_I[3]) begin
         fail_q <= 1'b0; timeout_q <= 1'b0; // see RQ18
      end
      FL_RESET_N_O <= ~(wr & hit_ctrl & PWDATA_I[4]); // see RQ18
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               op_q <= PWDATA_I[2:0]; busy_q <= 1'b1; timeout_q <= 1'b0;
               FL_ADDR_O <= addr_q; FL_CE_N_O <= 1'b0; phase_q <= 16'h0; wait_q <= 16'h0;
               // suspend/resume carry only data; FL_ADDR_O still takes addr_q as for every op, see RQ4
               if (PWDATA_I[2:0] == `FESC_OP_SUSPEND) begin
                  FL_DQ_O <= susp_code_q; FL_DQ_OE_O <= 1'b1; // see RQ1
               end else if (PWDATA_I[2:0] == `FESC_OP_RESUME) begin
                  FL_DQ_O <= `FESC_CMD_RESUME; FL_DQ_OE_O <= 1'b1; // see RQ9
               end else if (PWDATA_I[2:0] == `FESC_OP_WRITE) begin
                  FL_DQ_O <= wdata_q; FL_DQ_OE_O <= 1'b1;
               end else begin
                  FL_DQ_OE_O <= 1'b0;
               end
               state_q <= ST_SETUP;
            end
         end
         ST_SETUP: begin
            phase_q <= phase_q + 16'h1;
            if (phase_q == PHASE_CYC[15:0]) begin
               phase_q <= 16'h0;
               if (FL_DQ_OE_O) FL_WE_N_O <= 1'b0; else FL_OE_N_O <= 1'b0; // see RQ22
               state_q <= ST_STROB;
            end
         end
         ST_STROB: begin
            phase_q <= phase_q + 16'h1;
            if (phase_q == PHASE_CYC[15:0]) begin
               phase_q <= 16'h0;
               if (!FL_OE_N_O) begin
                  rdata_q <= new_dq;
                  // a toggle shows only between two successive reads, see RQ15
                  if (have_prev_q) begin
                     tog1_q <= new_dq[`FESC_DQ_TOG1] ^ prev_q[`FESC_DQ_TOG1]; // see RQ6
                     tog2_q <= new_dq[`FESC_DQ_TOG2] ^ prev_q[`FESC_DQ_TOG2]; // see RQ21
                  end
                  prev_q <= new_dq; have_prev_q <= 1'b1;
                  in_erase_q <= new_dq[`FESC_DQ_WIN]; // see RQ19 RQ20
                  if (new_dq[`FESC_DQ_FAIL]) fail_q <= 1'b1; // see RQ17
               end else begin
                  have_prev_q <= 1'b0;
               end
               FL_WE_N_O <= 1'b1; FL_OE_N_O <= 1'b1;
               state_q <= ST_HOLD;
            end
         end
         ST_HOLD: begin
            phase_q <= phase_q + 16'h1;
            if (phase_q == PHASE_CYC[15:0]) begin
               phase_q <= 16'h0; FL_CE_N_O <= 1'b1; FL_DQ_OE_O <= 1'b0;
               if (op_q == `FESC_OP_SUSPEND) begin
                  suspended_q <= 1'b1; erasing_q <= 1'b0; // see RQ7
                  state_q <= ST_WAIT;
               end else if (op_q == `FESC_OP_RESUME) begin
                  suspended_q <= 1'b0; erasing_q <= 1'b1; // see RQ9
                  state_q <= ST_DONE;
               end else if (op_q == `FESC_OP_WAITSUSP || op_q == `FESC_OP_POLL) begin
                  state_q <= ST_WAIT;
               end else begin
                  state_q <= ST_DONE;
               end
            end
         end
         ST_WAIT: begin
            // wait for release of busy or settled toggle, bounded by the suspend limit
            wait_q <= wait_q + 16'h1;
            if (((op_q == `FESC_OP_SUSPEND) || (op_q == `FESC_OP_WAITSUSP)) && rb_q) begin
               state_q <= ST_DONE; // see RQ12
            end else if (op_q == `FESC_OP_POLL && have_prev_q && !tog1_q) begin
               state_q <= ST_DONE; // see RQ15
            end else if (wait_q >= SUSP_CYCLES[15:0]) begin
               timeout_q <= 1'b1; state_q <= ST_DONE; // see RQ5
            end else if (op_q == `FESC_OP_POLL) begin
               FL_CE_N_O <= 1'b0; FL_DQ_OE_O <= 1'b0; state_q <= ST_SETUP; // see RQ16
            end
         end
         ST_DONE: begin
            busy_q <= 1'b0; state_q <= ST_IDLE;
         end
         default: state_q <= ST_IDLE;
      endcase
   end
end
endmodule

// File: tb/fesc_ctrl_sva.sv
// assertion checker for the flash erase suspend controller ports
`timescale 1ns/1ns
`include "fesc_map.vh"
module fesc_ctrl_sva (
   input wire        CLK_I,
   input wire        RESETN_I,
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   input wire        FL_CE_N_O,
   input wire        FL_OE_N_O,
   input wire        FL_WE_N_O,
   input wire [7:0]  FL_DQ_O,
   input wire        FL_DQ_OE_O,
   input wire        FL_RESET_N_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   // only a write taken while the flash bus is idle starts an operation
   wire ctrl_wr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == `FESC_REG_CTRL && FL_CE_N_O;
   a_resume_byte_out: assert property (ctrl_wr && PWDATA_I[2:0] == `FESC_OP_RESUME |->
      ##[1:30] (!FL_WE_N_O && FL_DQ_O == `FESC_CMD_RESUME)) else $error("resume byte missing");
   a_suspend_byte_out: assert property (ctrl_wr && PWDATA_I[2:0] == `FESC_OP_SUSPEND |->
      ##[1:30] (!FL_WE_N_O && FL_DQ_O != `FESC_CMD_RESUME)) else $error("suspend byte wrong");
   a_reset_pulse_start: assert property (ctrl_wr && PWDATA_I[4] |-> ##[1:3] !FL_RESET_N_O)
      else $error("flash reset not pulsed");
   a_reset_pulse_width: assert property ($fell(FL_RESET_N_O) |=> FL_RESET_N_O)
      else $error("flash reset pulse too long");
   a_write_strobe_shape: assert property ($fell(FL_WE_N_O) |->
      (!FL_WE_N_O && FL_DQ_OE_O && !FL_CE_N_O) [*6] ##1 FL_WE_N_O) else $error("write strobe bad");
   a_status_read_clean: assert property (!FL_OE_N_O |-> !FL_DQ_OE_O && FL_WE_N_O && !FL_CE_N_O)
      else $error("status read contends");
endmodule
bind fesc_ctrl fesc_ctrl_sva fesc_ctrl_sva_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .FL_CE_N_O(FL_CE_N_O),
   .FL_OE_N_O(FL_OE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O),
   .FL_RESET_N_O(FL_RESET_N_O));

// File: tb/fesc_flash_model.sv
// behavioural flash device model: sector erase with suspend, resume and status bits
`timescale 1ns/1ns
module fesc_flash_model #(
   parameter SUSP_NS = 400
) (
   input  wire        ce_n_i,
   input  wire        oe_n_i,
   input  wire        we_n_i,
   input  wire        rst_n_i,
   input  wire        erase_i,
   input  wire [19:0] addr_i,
   input  wire [7:0]  dq_i,
   output wire [7:0]  dq_o,
   output wire        busy_pull_o
);
   reg       erasing = 1'b0;
   reg       susp    = 1'b0;
   reg       tog     = 1'b0;
   reg [7:0] last    = 8'h00;
   // poll 0 while erasing, window closed, both toggles on the same read count
   // no protected sectors and no failing sectors here, so the fail bit stays 0
   wire [7:0] stat = {1'b0, tog, 2'b00, 1'b1, tog, 2'b00};
   wire [7:0] val  = (erasing && !susp) ? stat : (addr_i[7:0] ^ 8'h5a);
   // released bus shows the inverse of the last value, never a stale copy
   assign dq_o = (ce_n_i | oe_n_i) ? ~last : val;
   assign busy_pull_o = erasing && !susp;
   always @(posedge (ce_n_i | oe_n_i)) begin
      last = val;
      if (erasing && !susp) tog = ~tog;
   end
   // address ignored; repeats fall through unchanged; other bytes discarded
   always @(posedge we_n_i) begin
      if (dq_i == 8'h30 && susp) begin
         susp = 1'b0;
         tog  = ~tog;
      end else if (dq_i == 8'hb0 && erasing && !susp) begin
         #SUSP_NS susp = 1'b1;
      end
   end
   always @(negedge rst_n_i) begin
      erasing = 1'b0;
      susp    = 1'b0;
   end
   always @(posedge erase_i) erasing = 1'b1;
endmodule

// File: tb/fesc_ctrl_tb_top.sv
// self-checking testbench for the flash erase suspend controller
`timescale 1ns/1ns
`include "fesc_map.vh"
module fesc_ctrl_tb_top;
   logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, erase = 0, busy_pull;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd, a;
   logic [7:0]  s0, dq_in;
   logic [19:0] fl_addr;
   logic        ce_n, oe_n, we_n, dq_oe, fl_rst_n, err;
   logic [7:0]  dq_out;
   int          fails = 0, total_checks = 0, i, n;
   logic        slverr;
   wire [31:0]  rd_w;
   wire         rdy;
   initial forever #10 clk = ~clk;
   fesc_ctrl fesc_ctrl_inst (.CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(rd_w), .PREADY_O(rdy), .PSLVERR_O(err),
      .FL_ADDR_O(fl_addr), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n), .FL_DQ_I(dq_in),
      .FL_DQ_O(dq_out), .FL_DQ_OE_O(dq_oe), .FL_READY_BUSY_N_I(~busy_pull), .FL_RESET_N_O(fl_rst_n));
   fesc_flash_model fesc_flash_model_inst (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(fl_rst_n),
      .erase_i(erase), .addr_i(fl_addr), .dq_i(dq_out), .dq_o(dq_in), .busy_pull_o(busy_pull));
   task end_of_test;
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge clk) penable <= 1;
      n = 0;
      do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin fails++; end_of_test; end
      rd = rd_w;
      slverr = err;
      psel <= 0; penable <= 0;
      @(posedge clk);
   endtask
   // start an operation and poll until busy clears; rd ends holding status
   task op(input logic [31:0] c, input logic [31:0] ad);
      apb(1, `FESC_REG_ADDR, ad);
      apb(1, `FESC_REG_CTRL, c);
      i = 0;
      do begin apb(0, `FESC_REG_STATUS, 0); i++; end while (rd[5] !== 1'b0 && i < 400);
      if (rd[5] !== 1'b0) begin fails++; end_of_test; end
   endtask
   // a suspended device reads out an address-derived pattern from non-erasing sectors
   function automatic logic [7:0] susp_byte(input logic [31:0] ad);
      return ad[7:0] ^ 8'h5a;
   endfunction
   initial begin
      void'($urandom(32'h42ab3e50));
      repeat (5) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      apb(1, `FESC_REG_SUSPCODE, 32'h30);
      apb(0, `FESC_REG_SUSPCODE, 0); chk("suspcode", 32'hb0, rd);
      apb(0, 12'h018, 0); chk("unmapped_err", 1, slverr);
      chk("unmapped_rdata", 0, rd);
      erase <= 1;
      repeat (4) @(posedge clk);
      apb(0, `FESC_REG_STATUS, 0); chk("rb_busy", 0, rd[7]);
      op(`FESC_OP_READ, $urandom); apb(0, `FESC_REG_RDATA, 0); s0 = rd[7:0];
      op(`FESC_OP_READ, $urandom); apb(0, `FESC_REG_RDATA, 0);
      chk("poll_bit", 0, rd[7]);
      chk("window_bit", 1, rd[3]);
      chk("toggle_one", {31'h0, ~s0[6]}, rd[6]);
      for (int k = 0; k < 3; k++) begin
         op(`FESC_OP_SUSPEND, 0);
         if (k == 1) op(`FESC_OP_SUSPEND, $urandom);
         chk("rb_suspended", 1, rd[7]);
         chk("suspended", 1, rd[12]);
         a = $urandom;
         op(`FESC_OP_READ, a); apb(0, `FESC_REG_RDATA, 0); chk("susp_read", {24'h0, susp_byte(a)}, rd);
         // a program byte equal to a resume or suspend code would change the erase state
         a = $urandom;
         if (a[7:0] == `FESC_CMD_RESUME || a[7:0] == `FESC_CMD_SUSP_RST) a[7:0] = 8'h00;
         apb(1, `FESC_REG_DATA, a);
         op(`FESC_OP_WRITE, a); chk("susp_write_kept", 1, rd[12]);
         chk("susp_write_ready", 1, rd[7]);
         if (k == 0) begin
            op(`FESC_OP_WAITSUSP, 0); chk("waitsusp_ready", 1, rd[7]);
            op(`FESC_OP_POLL, 0); chk("poll_tog1", 0, rd[8]);
            chk("poll_no_timeout", 0, rd[6]);
         end
         op(`FESC_OP_RESUME, $urandom); chk("rb_resumed", 0, rd[7]);
      end
      op(32'h10, 0); apb(0, `FESC_REG_STATUS, 0); chk("rb_after_reset", 1, rd[7]);
      end_of_test;
   end
endmodule
